// >>> src/ctx_bank_pkg.sv
// Package for the stage 2 context bank upper register space.
// Assumes a 32-bit Avalon-MM slave with byte addresses within the bank.
package ctx_bank_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_CNT = 15;
    // Register byte offsets
    localparam logic [11:0] OFS_FAR_LO = 12'h060;
    localparam logic [11:0] OFS_FAR_HI = 12'h064;
    localparam logic [11:0] OFS_SYN0 = 12'h068;
    localparam logic [11:0] OFS_SYN1 = 12'h06C;
    localparam logic [11:0] OFS_IPA_LO = 12'h070;
    localparam logic [11:0] OFS_IPA_HI = 12'h074;
    localparam logic [11:0] OFS_INV_LO = 12'h630;
    localparam logic [11:0] OFS_INV_HI = 12'h634;
    localparam logic [11:0] OFS_INVL_LO = 12'h638;
    localparam logic [11:0] OFS_INVL_HI = 12'h63C;
    localparam logic [11:0] OFS_SYNC = 12'h7F0;
    localparam logic [11:0] OFS_SYNC_ST = 12'h7F4;
    localparam logic [11:0] OFS_IMPL_LO = 12'hD00;
    localparam logic [11:0] OFS_IMPL_HI = 12'hDFC;
    localparam logic [11:0] OFS_CNT_LO = 12'hE00;
    localparam logic [11:0] OFS_CNT_HI = 12'hE38;
    localparam logic [11:0] OFS_TYP_LO = 12'hE80;
    localparam logic [11:0] OFS_TYP_HI = 12'hEB8;
    localparam logic [11:0] OFS_CFG = 12'hF00;
    localparam logic [11:0] OFS_CTRL = 12'hF04;
    localparam logic [11:0] OFS_CEID0 = 12'hF20;
    localparam logic [11:0] OFS_CEID1 = 12'hF24;
    localparam logic [11:0] OFS_CEN_SET = 12'hF40;
    localparam logic [11:0] OFS_CEN_CLR = 12'hF44;
    localparam logic [11:0] OFS_IEN_SET = 12'hF48;
    localparam logic [11:0] OFS_IEN_CLR = 12'hF4C;
    localparam logic [11:0] OFS_OVF_CLR = 12'hF50;
    localparam logic [11:0] OFS_OVF_SET = 12'hF58;
    localparam logic [11:0] OFS_AUTH = 12'hFB8;
    // Chosen offsets for bank status/mask (in the implementation window)
    localparam logic [11:0] OFS_IRQ_ST = 12'hD00;
    localparam logic [11:0] OFS_IRQ_MASK = 12'hD04;
    localparam int IMPL_WORDS = 62;          // D08..DFC user scratch
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int SYNC_ACTIVE_BIT = 0;
    localparam int BANKIDX_LSB = 16;
    localparam int BANKIDX_W = 8;
    localparam int EVT_W = 8;
    localparam int IRQ_INV = 0;
    localparam int IRQ_SYNC = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_W = 3;
    // Reset values and fixed contents (arbitrary identification-like values)
    localparam logic [31:0] CFG_VAL = 32'h00001F0E;
    localparam logic [31:0] CEID0_VAL = 32'h0000001F;
    localparam logic [31:0] CEID1_VAL = 32'h00000000;
    localparam logic [31:0] AUTH_VAL = 32'h00000000;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    // Timing: a sync waits out at least this drain time after the sync write
    localparam int SYNC_NS = 80;
    localparam int CLK_NS = 10;
    localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SYNC_CYC_W = 4'(SYNC_CYC);

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_t;

    typedef struct packed {
        logic [63:0] addr;
        logic last_level;
    } inval_t;

    typedef enum logic [1:0] {
        SY_IDLE = 2'b00,
        SY_BUSY = 2'b01,
        SY_DONE = 2'b11
    } sync_state_t;
endpackage

// >>> src/byte_merge.sv
// Byte-lane merge of a 32-bit write into a stored word.
// Assumes Avalon byteenable semantics.
module byte_merge
    import ctx_bank_pkg::*;
(
    input wire logic [31:0] old_word,
    input wire logic [31:0] new_word,
    input wire logic [3:0] be,
    output logic [31:0] merged
);
    // One mux per lane
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            merged[i*8 +: 8] = be[i] ? new_word[i*8 +: 8] : old_word[i*8 +: 8];
        end
    end
endmodule

// >>> src/perf_counter.sv
// One performance event counter with overflow pulse.
// Assumes same-clock event strobes.
module perf_counter
    import ctx_bank_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic count_en,
    input wire logic event_hit,
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic zero,
    output logic [31:0] value,
    output logic overflow
);
    typedef struct packed {
        logic [31:0] cnt;
        logic ovf;
    } cnt_state_t;
    cnt_state_t s_r, s_nxt;

    // Software load wins over counting to keep writes exact
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ovf = 1'b0;
        if (zero)
            s_nxt.cnt = ZERO32;
        else if (load)
            s_nxt.cnt = load_val;
        else if (count_en && event_hit)
        begin
            s_nxt.cnt = s_r.cnt + 32'h00000001;
            s_nxt.ovf = (s_r.cnt == 32'hFFFFFFFF);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign value = s_r.cnt;
    assign overflow = s_r.ovf;
endmodule

// >>> src/ctx_bank_regs.sv
// Stage 2 context bank: fault records, TLB maintenance, performance monitor.
// Assumes an Avalon-MM master on the same clock and a TLB that takes
// one invalidate pulse and reports idle as a same-clock level.

// Overview of operation
// [RULE1] 64-bit read-write fault address at 0x060, loaded by fault capture.
// [RULE2] 64-bit read-write intermediate fault address at 0x070.
// [RULE3] Two syndrome words at 0x068 and 0x06C capture abort details.
// [RULE4] Syndrome words are 32-bit read-write; reset value not guaranteed.
// [RULE5] Write at 0x630 issues invalidate by intermediate address.
// [RULE6] Write at 0x638 issues last-level invalidate by intermediate address.
// [RULE7] Write at 0x7F0 starts a sync of earlier invalidations.
// [RULE8] Read-only sync status at 0x7F4 shows sync still active.
// [RULE9] Words 0xD00 to 0xDFC are implementation read-write registers.
// [RULE10] Counters at 0xE00..0xE38, event selectors at 0xE80..0xEB8.
// [RULE11] Read-only config at 0xF00, read-write control at 0xF04.
// [RULE12] Read-only common event id words at 0xF20 and 0xF24.
// [RULE13] Count enables set at 0xF40, cleared at 0xF44 by ones.
// [RULE14] Interrupt enables set at 0xF48, cleared at 0xF4C by ones.
// [RULE15] Overflow flags cleared at 0xF50, set at 0xF58; 0xF54 reserved.
// [RULE16] Read-only authentication status at 0xFB8.
// [RULE17] Syndrome bits 23:16 hold first-stage bank index when nested.
// [RULE18] Reserved offsets read zero and ignore writes.
module ctx_bank_regs
    import ctx_bank_pkg::*;
#(
    parameter int COUNTERS = NUM_CNT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire logic fault_valid,
    input wire logic [63:0] fault_addr,
    input wire logic [63:0] fault_ipa,
    input wire logic [31:0] fault_syn0,
    input wire logic [31:0] fault_syn1,
    input wire logic fault_nested,
    input wire logic [BANKIDX_W-1:0] first_stage_bank_index,
    input wire logic [EVT_W-1:0] event_strobe,
    input wire logic tlb_idle,
    output inval_t inval_cmd,
    output logic inval_valid,
    output logic irq
);
    if (COUNTERS < 1 || COUNTERS > NUM_CNT)
    begin : g_bad_count
        $error("COUNTERS out of range");
    end

    typedef struct packed {
        logic [63:0] far;
        logic [63:0] ipa;
        logic [31:0] syn0;
        logic [31:0] syn1;
        logic [31:0] inv_lo;
        logic [31:0] invl_lo;
        logic [IMPL_WORDS-1:0][31:0] impl;
        logic [NUM_CNT-1:0][EVT_W-1:0] evtype;
        logic [31:0] ctrl;
        logic [NUM_CNT-1:0] cnt_en;
        logic [NUM_CNT-1:0] int_en;
        logic [NUM_CNT-1:0] ovf;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        sync_state_t sync;
        logic [3:0] sync_cnt;
        logic [31:0] rdata;
        logic waitreq;
        logic irq;
        inval_t inv;
        logic inv_v;
    } state_t;
    state_t s_r, s_nxt;

    logic [NUM_CNT-1:0][31:0] cnt_val;
    logic [NUM_CNT-1:0] cnt_ovf;
    logic [NUM_CNT-1:0] cnt_load;
    logic [NUM_CNT-1:0] cnt_hit;
    logic [31:0] wmerged;
    logic [31:0] wold;
    logic [ADDR_W-1:0] a;
    logic wr, rd;
    logic [ADDR_W-1:0] cnt_off;
    logic [ADDR_W-1:0] typ_off;
    logic [ADDR_W-1:0] impl_off;
    logic [3:0] cnt_idx;
    logic [3:0] typ_idx;
    logic [5:0] impl_idx;
    logic in_cnt, in_typ, in_impl;

    // Access taken in the cycle the request first appears; one wait cycle
    assign a = {av_req.address[ADDR_W-1:2], 2'b00};
    assign wr = av_req.write && s_r.waitreq;
    assign rd = av_req.read && s_r.waitreq;
    assign cnt_off = a - OFS_CNT_LO;
    assign typ_off = a - OFS_TYP_LO;
    assign impl_off = a - OFS_IRQ_ST;
    assign cnt_idx = cnt_off[5:2];
    assign typ_idx = typ_off[5:2];
    assign impl_idx = 6'(impl_off[7:2] - 6'h02);
    assign in_cnt = a >= OFS_CNT_LO && a <= OFS_CNT_HI
        && int'(cnt_idx) < COUNTERS; // RULE10
    assign in_typ = a >= OFS_TYP_LO && a <= OFS_TYP_HI
        && int'(typ_idx) < COUNTERS; // RULE10
    assign in_impl = a >= (OFS_IMPL_LO + 12'h008) && a <= OFS_IMPL_HI; // RULE9

    // Old word for byte merge, selected by address
    always_comb
    begin
        case (a)
            OFS_FAR_LO: wold = s_r.far[31:0];
            OFS_FAR_HI: wold = s_r.far[63:32];
            OFS_SYN0: wold = s_r.syn0;
            OFS_SYN1: wold = s_r.syn1;
            OFS_IPA_LO: wold = s_r.ipa[31:0];
            OFS_IPA_HI: wold = s_r.ipa[63:32];
            OFS_INV_LO: wold = s_r.inv_lo;
            OFS_INVL_LO: wold = s_r.invl_lo;
            OFS_CTRL: wold = s_r.ctrl;
            default:
            begin
                if (in_impl)
                    wold = s_r.impl[impl_idx];
                else if (in_cnt)
                    wold = cnt_val[cnt_idx];
                else if (in_typ)
                    wold = {{(32-EVT_W){1'b0}}, s_r.evtype[typ_idx]};
                else
                    wold = ZERO32;
            end
        endcase
    end

    byte_merge u_merge (
        .old_word(wold),
        .new_word(av_req.writedata),
        .be(av_req.byteenable),
        .merged(wmerged)
    );

    // Event selector picks one of the event strobes per counter
    always_comb
    begin
        for (int i = 0; i < NUM_CNT; i++)
        begin
            cnt_load[i] = wr && in_cnt && int'(cnt_idx) == i; // RULE10
            cnt_hit[i] = event_strobe[s_r.evtype[i][2:0]];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++)
        begin : g_cnt
            if (g < COUNTERS)
            begin : g_on
                perf_counter u_cnt (
                    .clock(clock),
                    .rst(rst),
                    .count_en(s_r.cnt_en[g] && s_r.ctrl[CTRL_EN_BIT]),
                    .event_hit(cnt_hit[g]),
                    .load(cnt_load[g]),
                    .load_val(wmerged),
                    .zero(wr && a == OFS_CTRL && wmerged[CTRL_RST_BIT]),
                    .value(cnt_val[g]),
                    .overflow(cnt_ovf[g])
                );
            end
            else
            begin : g_off
                assign cnt_val[g] = ZERO32;
                assign cnt_ovf[g] = 1'b0;
            end
        end
    endgenerate

    // Next state: bus decode, fault capture, sync engine, flags
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.waitreq = !((av_req.read || av_req.write) && s_r.waitreq);
        s_nxt.inv_v = 1'b0;
        // Hardware fault capture; software writes below take priority
        if (fault_valid)
        begin
            s_nxt.far = fault_addr; // RULE1
            s_nxt.ipa = fault_ipa; // RULE2
            s_nxt.syn0 = fault_syn0; // RULE3
            s_nxt.syn1 = fault_syn1; // RULE3
            if (fault_nested)
                s_nxt.syn0[BANKIDX_LSB +: BANKIDX_W] =
                    first_stage_bank_index; // RULE17
        end
        if (wr)
        begin
            case (a)
                OFS_FAR_LO: s_nxt.far[31:0] = wmerged; // RULE1
                OFS_FAR_HI: s_nxt.far[63:32] = wmerged; // RULE1
                OFS_SYN0: s_nxt.syn0 = wmerged; // RULE4
                OFS_SYN1: s_nxt.syn1 = wmerged; // RULE4
                OFS_IPA_LO: s_nxt.ipa[31:0] = wmerged; // RULE2
                OFS_IPA_HI: s_nxt.ipa[63:32] = wmerged; // RULE2
                OFS_INV_LO: s_nxt.inv_lo = wmerged;
                OFS_INV_HI:
                begin
                    s_nxt.inv = '{addr: {wmerged, s_r.inv_lo},
                        last_level: 1'b0}; // RULE5
                    s_nxt.inv_v = 1'b1; // RULE5
                end
                OFS_INVL_LO: s_nxt.invl_lo = wmerged;
                OFS_INVL_HI:
                begin
                    s_nxt.inv = '{addr: {wmerged, s_r.invl_lo},
                        last_level: 1'b1}; // RULE6
                    s_nxt.inv_v = 1'b1; // RULE6
                end
                OFS_SYNC:
                begin
                    s_nxt.sync = SY_BUSY; // RULE7
                    s_nxt.sync_cnt = SYNC_CYC_W;
                end
                OFS_CTRL:
                    s_nxt.ctrl = {30'h0, 1'b0, wmerged[CTRL_EN_BIT]}; // RULE11
                OFS_CEN_SET:
                    s_nxt.cnt_en = s_r.cnt_en
                        | wmerged[NUM_CNT-1:0]; // RULE13
                OFS_CEN_CLR:
                    s_nxt.cnt_en = s_r.cnt_en
                        & ~wmerged[NUM_CNT-1:0]; // RULE13
                OFS_IEN_SET:
                    s_nxt.int_en = s_r.int_en
                        | wmerged[NUM_CNT-1:0]; // RULE14
                OFS_IEN_CLR:
                    s_nxt.int_en = s_r.int_en
                        & ~wmerged[NUM_CNT-1:0]; // RULE14
                OFS_OVF_CLR:
                    s_nxt.ovf = s_r.ovf & ~wmerged[NUM_CNT-1:0]; // RULE15
                OFS_OVF_SET:
                    s_nxt.ovf = s_r.ovf | wmerged[NUM_CNT-1:0]; // RULE15
                OFS_IRQ_ST:
                    s_nxt.irq_st = s_r.irq_st & ~wmerged[IRQ_W-1:0];
                OFS_IRQ_MASK: s_nxt.irq_mask = wmerged[IRQ_W-1:0];
                default:
                begin
                    if (in_impl)
                        s_nxt.impl[impl_idx] = wmerged; // RULE9
                    else if (in_typ)
                        s_nxt.evtype[typ_idx] = wmerged[EVT_W-1:0]; // RULE10
                    // Counter words load through cnt_load; anything else is dropped  RULE18
                end
            endcase
        end
        // Sync waits out the drain time, then for the TLB to go idle
        case (s_r.sync)
            SY_IDLE: ;
            SY_BUSY:
            begin
                if (s_r.sync_cnt != 4'h0)
                    s_nxt.sync_cnt = s_r.sync_cnt - 4'h1;
                else if (tlb_idle && !s_r.inv_v)
                    s_nxt.sync = SY_DONE; // RULE8
            end
            SY_DONE: s_nxt.sync = SY_IDLE;
            default: s_nxt.sync = SY_IDLE;
        endcase
        // Hardware sets win over software clears
        s_nxt.ovf = s_nxt.ovf | cnt_ovf; // RULE15
        if (s_r.inv_v)
            s_nxt.irq_st[IRQ_INV] = 1'b1;
        if (s_r.sync == SY_DONE)
            s_nxt.irq_st[IRQ_SYNC] = 1'b1;
        if (|(s_r.ovf & s_r.int_en))
            s_nxt.irq_st[IRQ_OVF] = 1'b1;
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
        // Read mux; reserved words answer zero
        s_nxt.rdata = ZERO32;
        if (rd)
        begin
            case (a)
                OFS_FAR_LO: s_nxt.rdata = s_r.far[31:0];
                OFS_FAR_HI: s_nxt.rdata = s_r.far[63:32];
                OFS_SYN0: s_nxt.rdata = s_r.syn0;
                OFS_SYN1: s_nxt.rdata = s_r.syn1;
                OFS_IPA_LO: s_nxt.rdata = s_r.ipa[31:0];
                OFS_IPA_HI: s_nxt.rdata = s_r.ipa[63:32];
                OFS_SYNC_ST:
                    s_nxt.rdata[SYNC_ACTIVE_BIT] =
                        (s_r.sync == SY_BUSY); // RULE8
                OFS_CFG: s_nxt.rdata = CFG_VAL; // RULE11
                OFS_CTRL: s_nxt.rdata = s_r.ctrl; // RULE11
                OFS_CEID0: s_nxt.rdata = CEID0_VAL; // RULE12
                OFS_CEID1: s_nxt.rdata = CEID1_VAL; // RULE12
                OFS_CEN_SET, OFS_CEN_CLR:
                    s_nxt.rdata[NUM_CNT-1:0] = s_r.cnt_en; // RULE13
                OFS_IEN_SET, OFS_IEN_CLR:
                    s_nxt.rdata[NUM_CNT-1:0] = s_r.int_en; // RULE14
                OFS_OVF_CLR, OFS_OVF_SET:
                    s_nxt.rdata[NUM_CNT-1:0] = s_r.ovf; // RULE15
                OFS_AUTH: s_nxt.rdata = AUTH_VAL; // RULE16
                OFS_IRQ_ST: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_st;
                OFS_IRQ_MASK: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_mask;
                default:
                begin
                    if (in_impl || in_cnt || in_typ)
                        s_nxt.rdata = wold;
                end
            endcase
        end
    end

    // Syndrome reset is arbitrary in spirit; zero is used for determinism
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.sync <= SY_IDLE;
            s_r.waitreq <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // Waitrequest drops in the cycle after the request appears
    always_comb
    begin
        av_waitrequest = s_r.waitreq;
    end

    assign av_readdata = s_r.rdata;
    assign inval_cmd = s_r.inv;
    assign inval_valid = s_r.inv_v;
    assign irq = s_r.irq;
endmodule

// >>> verif/ctx_bank_regs_asserts.sv
// Concurrent checks on the context bank register block ports.
// Assumes it is bound to ctx_bank_regs and sees only its ports.
module ctx_bank_regs_chk
    import ctx_bank_pkg::*;
#(
    parameter int COUNTERS = NUM_CNT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire av_req_t av_req,
    input wire logic [31:0] av_readdata,
    input wire logic av_waitrequest,
    input wire inval_t inval_cmd,
    input wire logic inval_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Request taken at this edge; high-word writes fire invalidates
    logic taken;
    logic wr_inv;
    logic wr_invl;
    assign taken = (av_req.read || av_req.write) && av_waitrequest;
    assign wr_inv = av_req.write && av_waitrequest
        && av_req.address == OFS_INV_HI;
    assign wr_invl = av_req.write && av_waitrequest
        && av_req.address == OFS_INVL_HI;

    property p_answer;
        taken |=> !av_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("Request not answered after one cycle");
    property p_ack_pulse;
        !av_waitrequest |=> av_waitrequest;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("Answer held longer than one cycle");
    property p_ack_cause;
        $fell(av_waitrequest) |-> $past(av_req.read || av_req.write);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("Answer without a request");
    property p_rdata_idle;
        av_waitrequest |-> av_readdata == ZERO32;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data not zero outside an answer");
    property p_inv;
        wr_inv |=> inval_valid && !inval_cmd.last_level
            && inval_cmd.addr[63:32] == $past(av_req.writedata);
    endproperty
    a_inv: assert property (p_inv)
        else $error("Invalidate by address not issued");
    property p_invl;
        wr_invl |=> inval_valid && inval_cmd.last_level;
    endproperty
    a_invl: assert property (p_invl)
        else $error("Last level invalidate not issued");
    property p_inv_cause;
        inval_valid |-> $past(wr_inv || wr_invl) ##1 !inval_valid;
    endproperty
    a_inv_cause: assert property (p_inv_cause)
        else $error("Invalidate pulse without a command write");
    property p_rsvd;
        av_req.read && av_waitrequest
            && av_req.address inside {[12'h078:12'h62C]}
            |=> av_readdata == ZERO32;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved word read not zero");
    property p_cfg;
        av_req.read && av_waitrequest && av_req.address == OFS_CFG
            |=> av_readdata == CFG_VAL;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("Configuration word wrong");
endmodule

// >>> verif/stage2_ctx_fault_tlb_pmu_regs_tb_top.sv
// Self-checking bench for the context bank register block.
// Assumes the block answers each bus request one cycle after it appears.
module stage2_ctx_fault_tlb_pmu_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ctx_bank_pkg::*;
    logic clock, rst, fault_valid, fault_nested, tlb_idle;
    logic av_waitrequest, inval_valid, irq;
    av_req_t req;
    logic [31:0] av_readdata, fault_syn0, fault_syn1, rd;
    logic [63:0] fault_addr, fault_ipa;
    logic [7:0] bank_idx, event_strobe;
    inval_t inval_cmd, inv_seen;
    int miscompares = 0;
    int cmp_count = 0;
    int inv_cnt = 0;

    ctx_bank_regs #(.COUNTERS(NUM_CNT)) dut_u (.clock(clock), .rst(rst),
        .av_req(req), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .fault_valid(fault_valid),
        .fault_addr(fault_addr), .fault_ipa(fault_ipa),
        .fault_syn0(fault_syn0), .fault_syn1(fault_syn1),
        .fault_nested(fault_nested), .first_stage_bank_index(bank_idx),
        .event_strobe(event_strobe), .tlb_idle(tlb_idle),
        .inval_cmd(inval_cmd), .inval_valid(inval_valid), .irq(irq));

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Record invalidate pulses; they stand one cycle only
    always @(posedge clock)
    begin
        if (inval_valid === 1'b1)
        begin
            inv_seen <= inval_cmd;
            inv_cnt <= inv_cnt + 1;
        end
    end

    task automatic chk(input string name, input logic [63:0] exp,
        input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bus write: hold the request until waitrequest is seen low
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        req <= '{a, 1'b0, 1'b1, d, 4'hF};
        do @(posedge clock); while (av_waitrequest !== 1'b0);
        req.write <= 1'b0;
        @(posedge clock);
    endtask

    // Bus read; data taken at the edge that sees waitrequest low
    task automatic rd_chk(input string name, input logic [11:0] a,
        input logic [31:0] exp);
        req <= '{a, 1'b1, 1'b0, 32'h0, 4'hF};
        do @(posedge clock); while (av_waitrequest !== 1'b0);
        rd = av_readdata;
        req.read <= 1'b0;
        @(posedge clock);
        chk(name, {32'h0, exp}, {32'h0, rd});
    endtask

    task automatic t_ro;
        logic [11:0] a [4];
        logic [31:0] v [4];
        a = '{OFS_CFG, OFS_CEID0, OFS_CEID1, OFS_AUTH};
        v = '{CFG_VAL, CEID0_VAL, CEID1_VAL, AUTH_VAL};
        foreach (a[i])
        begin
            wr(a[i], ~v[i]);
            rd_chk("read_only", a[i], v[i]);
        end
    endtask

    task automatic t_fault;
        fault_addr <= 64'h0123456789ABCDEF;
        fault_ipa <= 64'h000000FEDCBA9000;
        fault_syn0 <= 32'hA5A5A5A5;
        fault_syn1 <= 32'h5A5A5A5A;
        fault_nested <= 1'b1;
        bank_idx <= 8'h3C;
        fault_valid <= 1'b1;
        @(posedge clock);
        fault_valid <= 1'b0;
        @(posedge clock);
        rd_chk("far_lo", OFS_FAR_LO, 32'h89ABCDEF);
        rd_chk("far_hi", OFS_FAR_HI, 32'h01234567);
        rd_chk("ipa_lo", OFS_IPA_LO, 32'hDCBA9000);
        rd_chk("ipa_hi", OFS_IPA_HI, 32'h000000FE);
        rd_chk("syn0", OFS_SYN0, 32'hA53CA5A5);
        rd_chk("syn1", OFS_SYN1, 32'h5A5A5A5A);
    endtask

    // Read-write words, including ends of the window and counter bank
    task automatic t_rw;
        logic [11:0] a [9];
        logic [31:0] v [9];
        a = '{OFS_FAR_LO, OFS_FAR_HI, OFS_SYN0, OFS_SYN1, OFS_IPA_HI,
            12'hD08, OFS_IMPL_HI, OFS_CNT_HI, OFS_TYP_HI};
        v = '{32'hC3C30001, 32'h3C3C0002, 32'h11223344, 32'h55667788,
            32'h00000099, 32'hDEAD0006, 32'hBEEF0007, 32'h12345678,
            32'h00000077};
        foreach (a[i])
        begin
            wr(a[i], v[i]);
            rd_chk("rw_word", a[i], v[i]);
        end
    endtask

    task automatic t_rsvd;
        logic [11:0] a [11];
        a = '{12'h078, 12'h62C, 12'h640, 12'h7F8, 12'hCFC, 12'hE3C,
            12'hEBC, 12'hF08, 12'hF54, 12'hFB4, 12'hFCC};
        foreach (a[i])
        begin
            wr(a[i], 32'hFFFFFFFF);
            rd_chk("reserved", a[i], 32'h0);
        end
    endtask

    task automatic t_inval;
        wr(OFS_INV_LO, 32'h89AB0000);
        wr(OFS_INV_HI, 32'h00000012);
        chk("inv_count", 64'h1, inv_cnt);
        chk("inv_addr", 64'h0000001289AB0000, inv_seen.addr);
        chk("inv_last", 64'h0, inv_seen.last_level);
        wr(OFS_INVL_LO, 32'h00004000);
        wr(OFS_INVL_HI, 32'h00000003);
        chk("invl_count", 64'h2, inv_cnt);
        chk("invl_addr", 64'h0000000300004000, inv_seen.addr);
        chk("invl_last", 64'h1, inv_seen.last_level);
    endtask

    // Sync held busy by a slow TLB, then completion sets the status bit; the interrupt rises once unmasked
    task automatic t_sync;
        wr(OFS_IRQ_ST, 32'h7);
        tlb_idle <= 1'b0;
        wr(OFS_SYNC, 32'h1);
        rd_chk("sync_busy", OFS_SYNC_ST, 32'h1);
        repeat (12) @(posedge clock);
        rd_chk("sync_wait", OFS_SYNC_ST, 32'h1);
        tlb_idle <= 1'b1;
        repeat (12) @(posedge clock);
        rd_chk("sync_done", OFS_SYNC_ST, 32'h0);
        rd_chk("irq_status", OFS_IRQ_ST, 32'h2);
        chk("irq_masked", 64'h0, irq);
        wr(OFS_IRQ_MASK, 32'h2);
        @(posedge clock);
        chk("irq_raised", 64'h1, irq);
        wr(OFS_IRQ_ST, 32'h2);
        @(posedge clock);
        chk("irq_cleared", 64'h0, irq);
        wr(OFS_IRQ_MASK, 32'h0);
    endtask

    // Counter wraps, then stops once its enable is cleared
    task automatic t_pmu;
        wr(OFS_CNT_LO, 32'hFFFFFFFE);
        wr(OFS_TYP_LO, 32'h00000002);
        wr(OFS_CEN_SET, 32'h1);
        wr(OFS_CTRL, 32'h1);
        event_strobe <= 8'h04;
        repeat (3) @(posedge clock);
        event_strobe <= 8'h00;
        @(posedge clock);
        rd_chk("counter", OFS_CNT_LO, 32'h1);
        rd_chk("ovf_set", OFS_OVF_SET, 32'h1);
        wr(OFS_OVF_CLR, 32'h1);
        rd_chk("ovf_cleared", OFS_OVF_SET, 32'h0);
        wr(OFS_OVF_SET, 32'h1);
        rd_chk("ovf_forced", OFS_OVF_SET, 32'h1);
        rd_chk("cnt_en", OFS_CEN_SET, 32'h1);
        wr(OFS_CEN_CLR, 32'h1);
        rd_chk("cnt_dis", OFS_CEN_SET, 32'h0);
        event_strobe <= 8'h04;
        repeat (2) @(posedge clock);
        event_strobe <= 8'h00;
        rd_chk("counter_held", OFS_CNT_LO, 32'h1);
        wr(OFS_IEN_SET, 32'h00004001);
        rd_chk("int_en", OFS_IEN_SET, 32'h00004001);
        wr(OFS_IEN_CLR, 32'h00004000);
        rd_chk("int_dis", OFS_IEN_SET, 32'h00000001);
    endtask

    task automatic finish_test;
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence: reset for six cycles, then each scenario
    initial
    begin
        req = '0;
        rst = 1'b1;
        fault_valid = 1'b0;
        fault_nested = 1'b0;
        tlb_idle = 1'b1;
        fault_addr = '0;
        fault_ipa = '0;
        fault_syn0 = '0;
        fault_syn1 = '0;
        bank_idx = '0;
        event_strobe = '0;
        repeat (6) @(posedge clock);
        chk("rst_wait", 64'h1, av_waitrequest);
        chk("rst_irq", 64'h0, irq);
        rst <= 1'b0;
        @(posedge clock);
        t_ro();
        t_fault();
        t_rw();
        t_rsvd();
        t_inval();
        t_sync();
        t_pmu();
        finish_test();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        miscompares++;
        finish_test();
    end
endmodule

bind ctx_bank_regs ctx_bank_regs_chk #(.COUNTERS(COUNTERS)) chk_u (
    .clock(clock), .rst(rst), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .inval_cmd(inval_cmd),
    .inval_valid(inval_valid));
